// >>> common/pcw_pkg.sv
`default_nettype none
// Shared constants for the primary control word decoder.
package pcw_pkg;

    // Serial word layout.
    localparam int WORD_W       = 16;
    localparam int DAC_W        = 14;
    localparam int DAC_LSB_POS  = 2;
    localparam int CTRL_LO_POS  = 0;
    localparam int CTRL_HI_POS  = 1;
    localparam int BIT_CNT_W    = 5;

    // Framing defaults; the sample period is in system clock periods, the others are widths and a depth.
    localparam int DEF_SAMPLE_PERIOD = 64;
    localparam int DEF_CNT_W         = 16;
    localparam int DEF_OFS_W         = 8;
    localparam int DEF_FIFO_DEPTH    = 16;

    // Register bus layout.
    localparam int REG_ADDR_W = 8;
    localparam int REG_DATA_W = 32;
    localparam logic [7:0] REG_PHASE_OFFSET = 8'h00;
    localparam logic [7:0] REG_STATUS       = 8'h04;
    localparam logic [7:0] REG_SEC_WORD     = 8'h08;
    localparam logic [7:0] REG_DAC_WORD     = 8'h0C;
    localparam logic [7:0] RST_PHASE_OFFSET = 8'h00;

    // Status register field positions.
    localparam int ST_SEC_PEND_POS  = 0;
    localparam int ST_LAST_DLY_POS  = 1;
    localparam int ST_LAST_ADV_POS  = 2;
    localparam int ST_LAST_SEC_POS  = 3;
    localparam int ST_UNDERRUN_POS  = 4;
    localparam int ST_LEVEL_LSB_POS = 8;

    // Action bits produced by the decode table.
    localparam int ACT_SEC_POS = 2;
    localparam int ACT_DLY_POS = 1;
    localparam int ACT_ADV_POS = 0;

    // Decode table indexed by {ctrl_hi, ctrl_lo, pin_hi, pin_lo}; codes left out do nothing.
    localparam logic [2:0] ACT_TABLE [16] = '{
        3'h0, 3'h2, 3'h1, 3'h4,
        3'h2, 3'h0, 3'h0, 3'h6,
        3'h1, 3'h0, 3'h0, 3'h5,
        3'h4, 3'h6, 3'h6, 3'h4
    };

    // Frame engine states.
    typedef enum logic [1:0] {
        PCW_ST_GAP = 2'b00,
        PCW_ST_PRI = 2'b01,
        PCW_ST_SEC = 2'b10
    } pcw_state_t;

endpackage
`default_nettype wire

// >>> hdl/pcw_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// Small synchronous FIFO with valid and ready on both sides.
module pcw_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int LVL_W = $clog2(DEPTH) + 1
) (
    // Clock, reset and enable.
    input  wire logic             i_clk_sys,
    input  wire logic             i_rst,
    input  wire logic             i_ce,
    // Filling side.
    input  wire logic [WIDTH-1:0] i_in_data,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    // Draining side.
    output logic [WIDTH-1:0]      o_out_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    // Fill level.
    output logic [LVL_W-1:0]      o_level
);
    localparam int PTR_W = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic [LVL_W-1:0] level_r;
    wire              push;
    wire              pop;

    // Full and empty come straight from the level, so neither can lie.
    assign o_in_ready  = (level_r != LVL_W'(DEPTH));
    assign o_out_valid = (level_r != '0);
    assign o_out_data  = mem_r[rd_ptr_r];
    assign o_level     = level_r;
    assign push        = i_in_valid & o_in_ready;
    assign pop         = i_out_ready & o_out_valid;

    // Storage is written only on a push; it needs no reset.
    always_ff @(posedge i_clk_sys) begin
        if (i_ce && push) begin
            mem_r[wr_ptr_r] <= i_in_data;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            wr_ptr_r <= '0;
            rd_ptr_r <= '0;
            level_r  <= '0;
        end else if (i_ce) begin
            if (push) begin
                wr_ptr_r <= (wr_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= (rd_ptr_r == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
            end
            level_r <= level_r + LVL_W'(push) - LVL_W'(pop);
        end
    end

endmodule // pcw_fifo
`default_nettype wire

// >>> hdl/pcw_primary_control_word_decoder.sv
// The strobed register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module pcw_primary_control_word_decoder
    import pcw_pkg::*;
#(
    parameter int SAMPLE_PERIOD = DEF_SAMPLE_PERIOD,
    parameter int CNT_W         = DEF_CNT_W,
    parameter int OFS_W         = DEF_OFS_W,
    parameter int FIFO_DEPTH    = DEF_FIFO_DEPTH
) (
    // Clock, reset and enable.
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rst,
    input  wire logic                  i_ce,
    // Register port.
    input  wire logic [REG_ADDR_W-1:0] i_reg_addr,
    input  wire logic [REG_DATA_W-1:0] i_reg_wdata,
    input  wire logic                  i_reg_wr,
    input  wire logic                  i_reg_rd,
    output logic [REG_DATA_W-1:0]      o_reg_rdata,
    // Serial link pins.
    input  wire logic                  i_function_pin_lo,
    input  wire logic                  i_function_pin_hi,
    input  wire logic                  i_serial_din,
    output logic                       o_serial_dout,
    output logic                       o_frame_sync_n,
    output logic                       o_secondary_frame,
    // ADC samples from the converter side.
    input  wire logic [WORD_W-1:0]     i_adc_data,
    input  wire logic                  i_adc_valid,
    output logic                       o_adc_ready,
    // DAC words and secondary control words toward the converter side.
    output logic [DAC_W-1:0]           o_dac_data,
    output logic                       o_dac_valid,
    output logic [WORD_W-1:0]          o_sec_word,
    output logic                       o_sec_valid
);
    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    // Half period places the secondary frame; the minimum period keeps it clear of the next one.
    localparam logic [CNT_W-1:0] NOM_PERIOD = CNT_W'(SAMPLE_PERIOD);
    localparam logic [CNT_W-1:0] HALF_LAST  = CNT_W'(SAMPLE_PERIOD / 2 - 1);
    localparam logic [CNT_W:0]   MIN_PERIOD = (CNT_W + 1)'(SAMPLE_PERIOD / 2 + WORD_W + 2);
    localparam logic [BIT_CNT_W-1:0] LAST_BIT = BIT_CNT_W'(WORD_W);

    // Frame engine state.
    pcw_state_t           state_r;
    pcw_state_t           state_nxt;
    logic [CNT_W-1:0]     cnt_r;
    logic [CNT_W-1:0]     period_r;
    logic [BIT_CNT_W-1:0] bit_r;
    logic [WORD_W-1:0]    tx_r;
    logic [WORD_W-1:0]    rx_r;
    logic                 dout_r;
    logic                 fs_n_r;
    logic                 sec_pend_r;

    // Software-visible state.
    logic [OFS_W-1:0]      ofs_r;
    logic                  last_dly_r;
    logic                  last_adv_r;
    logic                  last_sec_r;
    logic                  underrun_r;
    logic [WORD_W-1:0]     sec_word_r;
    logic [DAC_W-1:0]      dac_word_r;
    logic                  dac_valid_r;
    logic                  sec_valid_r;
    logic [REG_DATA_W-1:0] rdata_r;

    // FIFO hookup.
    wire [WORD_W-1:0] fifo_data;
    wire              fifo_valid;
    wire              fifo_pop;
    wire [LVL_W-1:0]  fifo_level;

    // Sample period timing and frame starts.
    wire cnt_wrap    = (cnt_r == period_r - 1'b1);
    wire in_gap      = (state_r == PCW_ST_GAP);
    wire frame_start = in_gap & cnt_wrap;
    wire sec_start   = in_gap & sec_pend_r & (cnt_r == HALF_LAST) & ~cnt_wrap;
    wire in_shift    = (state_r == PCW_ST_PRI) | (state_r == PCW_ST_SEC);
    wire shift_done  = in_shift & (bit_r == LAST_BIT);
    wire pri_done    = shift_done & (state_r == PCW_ST_PRI);
    wire sec_done    = shift_done & (state_r == PCW_ST_SEC);

    // The word as it stands once its last bit is sampled.
    wire [WORD_W-1:0] word_in = {rx_r[WORD_W-2:0], i_serial_din};

    // Decode of the two control bits with the two pins, sampled in the last bit cycle.
    wire [3:0] act_code = {word_in[CTRL_HI_POS], word_in[CTRL_LO_POS],
                           i_function_pin_hi, i_function_pin_lo};
    wire [2:0] act      = ACT_TABLE[act_code];
    wire       act_sec  = act[ACT_SEC_POS];
    wire       act_dly  = act[ACT_DLY_POS];
    wire       act_adv  = act[ACT_ADV_POS];

    // Signed period arithmetic: a negative offset reverses the shift by itself.
    wire signed [CNT_W:0] nom_s = $signed({1'b0, NOM_PERIOD});
    wire signed [CNT_W:0] ofs_s = $signed({{(CNT_W + 1 - OFS_W){ofs_r[OFS_W-1]}}, ofs_r});
    wire signed [CNT_W:0] dly_s = nom_s + ofs_s;
    wire signed [CNT_W:0] adv_s = nom_s - ofs_s;
    wire signed [CNT_W:0] sel_s = act_dly ? dly_s : adv_s;
    wire                  short = (sel_s < $signed(MIN_PERIOD));
    wire [CNT_W:0]        adj_w = short ? MIN_PERIOD : $unsigned(sel_s);
    wire [CNT_W-1:0]      adj_period = adj_w[CNT_W-1:0];

    // The ADC word is taken at the frame start; an empty FIFO sends zero.
    assign fifo_pop = frame_start & fifo_valid;

    // Register decode.
    wire sel_ofs  = (i_reg_addr == REG_PHASE_OFFSET);
    wire sel_stat = (i_reg_addr == REG_STATUS);
    wire sel_sec  = (i_reg_addr == REG_SEC_WORD);
    wire sel_dac  = (i_reg_addr == REG_DAC_WORD);
    wire wr_ofs   = i_reg_wr & sel_ofs;
    wire clr_under = i_reg_wr & sel_stat & i_reg_wdata[ST_UNDERRUN_POS];

    // Status word layout.
    wire [REG_DATA_W-1:0] stat_word =
        (REG_DATA_W'(sec_pend_r) << ST_SEC_PEND_POS)  |
        (REG_DATA_W'(last_dly_r) << ST_LAST_DLY_POS)  |
        (REG_DATA_W'(last_adv_r) << ST_LAST_ADV_POS)  |
        (REG_DATA_W'(last_sec_r) << ST_LAST_SEC_POS)  |
        (REG_DATA_W'(underrun_r) << ST_UNDERRUN_POS)  |
        (REG_DATA_W'(fifo_level) << ST_LEVEL_LSB_POS);

    // Read mux; unmapped addresses read as zero.
    wire [REG_DATA_W-1:0] rd_mux =
        sel_ofs  ? REG_DATA_W'(ofs_r)      :
        sel_stat ? stat_word               :
        sel_sec  ? REG_DATA_W'(sec_word_r) :
        sel_dac  ? REG_DATA_W'(dac_word_r) : '0;

    // ADC buffer between the converter side and the serial transmitter.
    pcw_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH),
        .LVL_W (LVL_W)
    ) u_adc_fifo (
        .i_clk_sys   (i_clk_sys),
        .i_rst       (i_rst),
        .i_ce        (i_ce),
        .i_in_data   (i_adc_data),
        .i_in_valid  (i_adc_valid),
        .o_in_ready  (o_adc_ready),
        .o_out_data  (fifo_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (fifo_pop),
        .o_level     (fifo_level)
    );

    // Next state of the frame engine.
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            PCW_ST_GAP: begin
                if (frame_start) begin
                    state_nxt = PCW_ST_PRI;
                end else if (sec_start) begin
                    state_nxt = PCW_ST_SEC;
                end
            end
            PCW_ST_PRI: begin
                if (shift_done) begin
                    state_nxt = PCW_ST_GAP;
                end
            end
            PCW_ST_SEC: begin
                if (shift_done) begin
                    state_nxt = PCW_ST_GAP;
                end
            end
            default: begin
                state_nxt = PCW_ST_GAP;
            end
        endcase
    end

    // State register and bit counter of the running word.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            state_r <= PCW_ST_GAP;
            bit_r   <= '0;
        end else if (i_ce) begin
            state_r <= state_nxt;
            bit_r   <= in_shift ? bit_r + 1'b1 : '0;
        end
    end

    // Sample period counter; a shifted period lasts one frame, then the nominal one returns.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt_r    <= '0;
            period_r <= NOM_PERIOD;
        end else if (i_ce) begin
            cnt_r <= cnt_wrap ? '0 : cnt_r + 1'b1;
            if (pri_done && (act_dly || act_adv)) begin
                period_r <= adj_period;
            end else if (cnt_wrap) begin
                period_r <= NOM_PERIOD;
            end
        end
    end

    // Frame sync is one cycle low at the start of each frame, primary or secondary.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            fs_n_r <= 1'b1;
        end else if (i_ce) begin
            fs_n_r <= ~(frame_start | sec_start);
        end
    end

    // Shift path: bits leave MSB first and are sampled one cycle after they are driven.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            tx_r   <= '0;
            rx_r   <= '0;
            dout_r <= 1'b0;
        end else if (i_ce) begin
            if (frame_start) begin
                tx_r <= fifo_valid ? fifo_data : '0;
            end else if (sec_start) begin
                tx_r <= '0;
            end else if (in_shift) begin
                tx_r <= {tx_r[WORD_W-2:0], 1'b0};
            end
            if (in_shift && (bit_r != '0)) begin
                rx_r <= word_in;
            end
            dout_r <= (in_shift && !shift_done) ? tx_r[WORD_W-1] : 1'b0;
        end
    end

    // One pending request serves both sources; it is spent when the secondary frame starts.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sec_pend_r <= 1'b0;
        end else if (i_ce) begin
            if (pri_done) begin
                sec_pend_r <= act_sec;
            end else if (sec_start) begin
                sec_pend_r <= 1'b0;
            end
        end
    end

    // Last decode result, kept for software.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            last_dly_r <= 1'b0;
            last_adv_r <= 1'b0;
            last_sec_r <= 1'b0;
        end else if (i_ce && pri_done) begin
            last_dly_r <= act_dly;
            last_adv_r <= act_adv;
            last_sec_r <= act_sec;
        end
    end

    // Received words: DAC data on each primary frame, control word on each secondary one.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            dac_word_r  <= '0;
            dac_valid_r <= 1'b0;
            sec_word_r  <= '0;
            sec_valid_r <= 1'b0;
        end else if (i_ce) begin
            dac_valid_r <= pri_done;
            sec_valid_r <= sec_done;
            if (pri_done) begin
                dac_word_r <= word_in[WORD_W-1:DAC_LSB_POS];
            end
            if (sec_done) begin
                sec_word_r <= word_in;
            end
        end
    end

    // Underrun is sticky; a frame that underruns in the clearing cycle keeps it set.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            underrun_r <= 1'b0;
        end else if (i_ce) begin
            if (frame_start && !fifo_valid) begin
                underrun_r <= 1'b1;
            end else if (clr_under) begin
                underrun_r <= 1'b0;
            end
        end
    end

    // Phase offset register and registered read data.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ofs_r   <= OFS_W'(RST_PHASE_OFFSET);
            rdata_r <= '0;
        end else if (i_ce) begin
            if (wr_ofs) begin
                ofs_r <= i_reg_wdata[OFS_W-1:0];
            end
            rdata_r <= i_reg_rd ? rd_mux : '0;
        end
    end

    // Outputs.
    assign o_reg_rdata       = rdata_r;
    assign o_serial_dout     = dout_r;
    assign o_frame_sync_n    = fs_n_r;
    assign o_secondary_frame = (state_r == PCW_ST_SEC);
    assign o_dac_data        = dac_word_r;
    assign o_dac_valid       = dac_valid_r;
    assign o_sec_word        = sec_word_r;
    assign o_sec_valid       = sec_valid_r;

endmodule // pcw_primary_control_word_decoder
`default_nettype wire

// >>> common/pcw_pkg_note_unused.sv
`default_nettype none
`default_nettype wire

// >>> test/pcw_chk.sv
`timescale 1ns/1ps
`default_nettype none
module pcw_chk
    import pcw_pkg::*;
#(
    parameter int SAMPLE_PERIOD = DEF_SAMPLE_PERIOD
) (
    // Clock, reset and register port.
    input wire logic                  i_clk_sys,
    input wire logic                  i_rst,
    input wire logic [REG_ADDR_W-1:0] i_reg_addr,
    input wire logic [REG_DATA_W-1:0] i_reg_wdata,
    input wire logic                  i_reg_wr,
    input wire logic                  i_reg_rd,
    input wire logic [REG_DATA_W-1:0] o_reg_rdata,
    // Serial link and strobes.
    input wire logic                  i_function_pin_lo,
    input wire logic                  i_function_pin_hi,
    input wire logic                  i_serial_din,
    input wire logic                  o_serial_dout,
    input wire logic                  o_frame_sync_n,
    input wire logic                  o_secondary_frame,
    input wire logic                  o_dac_valid,
    input wire logic                  o_sec_valid
);
    localparam int HALF = SAMPLE_PERIOD / 2;
    logic [15:0]       cnt_r;
    logic [2:0]        act_r;
    logic              have_r;
    logic              bit1_r;
    logic signed [7:0] ofs_r;
    int                exp_per;
    wire               pfs = !o_frame_sync_n && !o_secondary_frame;
    wire               sfs = !o_frame_sync_n && o_secondary_frame;

    // Cycles since the last primary sync, and the action decoded in that frame.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cnt_r  <= 16'h0000;
            act_r  <= 3'h0;
            have_r <= 1'b0;
            bit1_r <= 1'b0;
            ofs_r  <= 8'h00;
        end else begin
            cnt_r  <= pfs ? 16'h0001 : cnt_r + 16'h0001;
            have_r <= have_r | pfs;
            bit1_r <= i_serial_din;
            if (cnt_r == 16'h0010)
                act_r <= ACT_TABLE[{bit1_r, i_serial_din, i_function_pin_hi, i_function_pin_lo}];
            if (i_reg_wr && i_reg_addr == REG_PHASE_OFFSET)
                ofs_r <= i_reg_wdata[7:0];
        end
    end

    // Expected period; the floor keeps a secondary frame room to finish.
    always_comb begin
        exp_per = SAMPLE_PERIOD;
        if (act_r[ACT_DLY_POS])
            exp_per = SAMPLE_PERIOD + int'(ofs_r);
        else if (act_r[ACT_ADV_POS])
            exp_per = SAMPLE_PERIOD - int'(ofs_r);
        if (exp_per < HALF + 18)
            exp_per = HALF + 18;
    end

    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);

    property p_fs_pulse; $fell(o_frame_sync_n) |=> o_frame_sync_n; endproperty
    a_fs_pulse: assert property (p_fs_pulse) else $error("sync low too long");
    property p_dac; pfs |-> ##17 o_dac_valid; endproperty
    a_dac: assert property (p_dac) else $error("no DAC word");
    property p_sec_dout; o_secondary_frame |-> !o_serial_dout; endproperty
    a_sec_dout: assert property (p_sec_dout) else $error("data out in secondary");
    property p_sec_word; sfs |-> ##17 o_sec_valid; endproperty
    a_sec_word: assert property (p_sec_word) else $error("no secondary word");
    property p_sec_half; sfs |-> $past(o_frame_sync_n, HALF) == 1'b0; endproperty
    a_sec_half: assert property (p_sec_half) else $error("secondary sync misplaced");
    property p_sec_req; have_r && cnt_r == HALF && act_r[ACT_SEC_POS] |-> sfs; endproperty
    a_sec_req: assert property (p_sec_req) else $error("secondary missing");
    property p_no_sec; have_r && cnt_r == HALF && !act_r[ACT_SEC_POS] |-> !o_secondary_frame;
    endproperty
    a_no_sec: assert property (p_no_sec) else $error("secondary unrequested");
    property p_period; have_r && pfs |-> cnt_r == 16'(exp_per); endproperty
    a_period: assert property (p_period) else $error("period wrong");
    property p_rd_idle; !$past(i_reg_rd) |-> o_reg_rdata == '0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");

    c_sec: cover property (o_sec_valid);
    c_dly: cover property (have_r && pfs && act_r[ACT_DLY_POS]);
    c_adv: cover property (have_r && pfs && act_r[ACT_ADV_POS]);
endmodule // pcw_chk

bind pcw_primary_control_word_decoder pcw_chk #(.SAMPLE_PERIOD(SAMPLE_PERIOD)) u_chk (
    .i_clk_sys, .i_rst, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .i_reg_rd, .o_reg_rdata,
    .i_function_pin_lo, .i_function_pin_hi, .i_serial_din, .o_serial_dout,
    .o_frame_sync_n, .o_secondary_frame, .o_dac_valid, .o_sec_valid
);
`default_nettype wire

// >>> test/pcw_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pcw_host_model (
    // Clock and reset.
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst,
    // Link pins from the device.
    input  wire logic        i_frame_sync_n,
    input  wire logic        i_secondary_frame,
    input  wire logic        i_serial_dout,
    // Words to send in primary and secondary frames.
    input  wire logic [15:0] i_pri_word,
    input  wire logic [15:0] i_sec_word,
    // Host side.
    output logic             o_serial_din,
    output logic [15:0]      o_rx_word,
    output logic             o_rx_done
);
    logic [4:0]  n_r;
    logic [15:0] sh_r;

    // One word each way per frame, MSB first; after the last bit the line shows
    // the inverse so a stale bit cannot pass for a driven one.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            n_r          <= 5'h00;
            sh_r         <= 16'h0000;
            o_serial_din <= 1'b0;
            o_rx_word    <= 16'h0000;
            o_rx_done    <= 1'b0;
        end else begin
            o_rx_done <= (n_r == 5'h01);
            if (!i_frame_sync_n) begin
                n_r          <= 5'h10;
                sh_r         <= i_secondary_frame ? i_sec_word : i_pri_word;
                o_serial_din <= i_secondary_frame ? i_sec_word[15] : i_pri_word[15];
            end else if (n_r != 5'h00) begin
                n_r          <= n_r - 5'h01;
                o_rx_word    <= {o_rx_word[14:0], i_serial_dout};
                o_serial_din <= (n_r > 5'h01) ? sh_r[n_r-5'h02] : ~o_serial_din;
            end
        end
    end
endmodule // pcw_host_model
`default_nettype wire

// >>> test/tb_primary_control_word_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module tb_primary_control_word_decoder;
    import pcw_pkg::*;
    localparam int SP = 64;
    localparam int DIR [16] = '{0, 1, -1, 0, 1, 0, 0, 1, -1, 0, 0, -1, 0, 1, 1, 0};
    localparam logic [15:0] SEC_MASK = 16'hF888;
    logic        clk, rst, wr, rd, pin_lo, pin_hi, adc_valid;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata;
    logic [15:0] adc_data, pri_w, sec_w, sec_word, rx;
    logic        din, dout, fs_n, sec, adc_ready, dac_valid, sec_valid, rx_done;
    logic [13:0] dac_data;
    int          cyc = 0, nsec = 0, error_cnt = 0, checked = 0;

    pcw_primary_control_word_decoder #(.SAMPLE_PERIOD(SP)) uut (
        .i_clk_sys(clk), .i_rst(rst), .i_ce(1'b1), .i_reg_addr(addr), .i_reg_wdata(wdata),
        .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_function_pin_lo(pin_lo),
        .i_function_pin_hi(pin_hi), .i_serial_din(din), .o_serial_dout(dout),
        .o_frame_sync_n(fs_n), .o_secondary_frame(sec), .i_adc_data(adc_data),
        .i_adc_valid(adc_valid), .o_adc_ready(adc_ready), .o_dac_data(dac_data),
        .o_dac_valid(dac_valid), .o_sec_word(sec_word), .o_sec_valid(sec_valid)
    );
    pcw_host_model u_host (
        .i_clk_sys(clk), .i_rst(rst), .i_frame_sync_n(fs_n), .i_secondary_frame(sec),
        .i_serial_dout(dout), .i_pri_word(pri_w), .i_sec_word(sec_w), .o_serial_din(din),
        .o_rx_word(rx), .o_rx_done(rx_done)
    );

    // Clock, cycle count and secondary sync count.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (fs_n === 1'b0 && sec === 1'b1) nsec <= nsec + 1;
    end

    task automatic check(input string name, input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic stop_test;
        if (error_cnt == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe.
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        d = rdata;
    endtask

    // Bounded wait: 0 primary sync, 1 secondary sync, 2 DAC, 3 secondary word, 4 host word.
    task automatic wait_ev(input int k);
        logic hit;
        hit = 1'b0;
        for (int n = 0; n < 300 && !hit; n++) begin
            @(posedge clk);
            case (k)
                0: hit = (fs_n === 1'b0) && (sec === 1'b0);
                1: hit = (fs_n === 1'b0) && (sec === 1'b1);
                2: hit = (dac_valid === 1'b1);
                3: hit = (sec_valid === 1'b1);
                default: hit = (rx_done === 1'b1);
            endcase
        end
        if (!hit) check("wait", 32'(k), 32'hFFFF_FFFF);
    endtask

    task automatic t_regs;
        logic [31:0] d;
        reg_rd(REG_PHASE_OFFSET, d);
        check("offset reset", d, 32'h0);
        reg_wr(REG_PHASE_OFFSET, 32'hFFFF_FF85);
        reg_rd(REG_PHASE_OFFSET, d);
        check("offset", d, 32'h0000_0085);
        reg_rd(8'h40, d);
        check("unmapped", d, 32'h0);
    endtask

    // Fill right after a sync so no pop interferes, then drain into an underrun.
    task automatic t_fifo;
        logic [31:0] d;
        wait_ev(0);
        reg_wr(REG_STATUS, 32'h10);
        for (int i = 0; i < 16; i++) begin
            @(posedge clk);
            adc_data  <= 16'hC300 + 16'(i);
            adc_valid <= 1'b1;
        end
        @(posedge clk);
        adc_valid <= 1'b0;
        reg_rd(REG_STATUS, d);
        check("level", 32'(d[12:8]), 32'h10);
        check("underrun clear", 32'(d[4]), 32'h0);
        check("ready", 32'(adc_ready), 32'h0);
        for (int i = 0; i < 17; i++) begin
            wait_ev(4);
            check("adc word", 32'(rx), (i < 16) ? 32'hC300 + 32'(i) : 32'h0);
        end
        reg_rd(REG_STATUS, d);
        check("underrun", 32'(d[4]), 32'h1);
    endtask

    // One decode code with its pins, then one nominal frame after it.
    task automatic t_case(input logic [3:0] c, input int ofs);
        logic [15:0] w;
        logic [31:0] d;
        int t0, s0;
        w = {10'h2A5, c, c[3:2]};
        pri_w <= w;
        sec_w <= ~w;
        wait_ev(0);
        t0 = cyc;
        s0 = nsec;
        pri_w <= 16'h0000;
        {pin_hi, pin_lo} <= c[1:0];
        wait_ev(2);
        check("dac data", 32'(dac_data), 32'(w[15:2]));
        {pin_hi, pin_lo} <= 2'b00;
        reg_rd(REG_STATUS, d);
        check("status", 32'(d[3:0]),
              32'({SEC_MASK[c], DIR[c] < 0, DIR[c] > 0, SEC_MASK[c]}));
        reg_rd(REG_DAC_WORD, d);
        check("dac reg", d, 32'(w[15:2]));
        if (SEC_MASK[c]) begin
            wait_ev(1);
            check("sec sync", 32'(cyc - t0), 32'(SP / 2));
            wait_ev(3);
            check("sec word", 32'(sec_word), {16'h0, ~w});
            reg_rd(REG_SEC_WORD, d);
            check("sec reg", d, {16'h0, ~w});
        end
        wait_ev(0);
        check("sec count", 32'(nsec - s0), 32'(SEC_MASK[c]));
        check("period", 32'(cyc - t0), 32'(SP + DIR[c] * ofs));
        t0 = cyc;
        wait_ev(0);
        check("next period", 32'(cyc - t0), 32'(SP));
    endtask

    // Main sequence.
    initial begin
        rst = 1'b1;
        {wr, rd, pin_lo, pin_hi, adc_valid} = 5'h00;
        addr = 8'h00;
        wdata = 32'h0;
        adc_data = 16'h0000;
        pri_w = 16'h0000;
        sec_w = 16'h0000;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_fifo;
        reg_wr(REG_PHASE_OFFSET, 32'h05);
        for (int c = 0; c < 16; c++) t_case(4'(c), 5);
        reg_wr(REG_PHASE_OFFSET, 32'hFB);
        t_case(4'h4, -5);
        t_case(4'h8, -5);
        stop_test;
    end

    // Watchdog, several times the expected run length.
    initial begin
        #200000;
        error_cnt++;
        stop_test;
    end
endmodule // tb_primary_control_word_decoder
`default_nettype wire
